/* File: include/ppc_pkg.sv */
// Constants shared by the palette pixel control register bank.
package ppc_pkg;

	// Register indices on the control register select pins.
	localparam logic [1:0] IDX_READ_MASK = 2'h0;
	localparam logic [1:0] IDX_BLINK_MASK = 2'h1;
	localparam logic [1:0] IDX_COMMAND = 2'h2;
	localparam logic [1:0] IDX_TEST = 2'h3;

	// Command register field positions.
	localparam int CMD_MUX_RATIO = 7;
	localparam int CMD_RAM_ENABLE = 6;
	localparam int CMD_RATE_HI = 5;
	localparam int CMD_RATE_LO = 4;
	localparam int CMD_HI_BLINK = 3;
	localparam int CMD_LO_BLINK = 2;
	localparam int CMD_HI_DISPLAY = 1;
	localparam int CMD_LO_DISPLAY = 0;

	// Test register field positions.
	localparam int TST_LOW_NIBBLE = 3;
	localparam int TST_BLUE = 2;
	localparam int TST_GREEN = 1;
	localparam int TST_RED = 0;

	// Blink rate codes and their on and whole-period lengths in retrace intervals.
	localparam logic [1:0] RATE_16_48 = 2'h0;
	localparam logic [1:0] RATE_16_16 = 2'h1;
	localparam logic [1:0] RATE_32_32 = 2'h2;
	localparam logic [1:0] RATE_64_64 = 2'h3;
	localparam logic [6:0] BLINK_ON_16 = 7'h10;
	localparam logic [6:0] BLINK_ON_32 = 7'h20;
	localparam logic [6:0] BLINK_ON_64 = 7'h40;
	localparam logic [7:0] BLINK_PERIOD_32 = 8'h20;
	localparam logic [7:0] BLINK_PERIOD_64 = 8'h40;
	localparam logic [7:0] BLINK_PERIOD_128 = 8'h80;

	// Load strobe periods of low blanking that mark a vertical retrace.
	localparam logic [8:0] RETRACE_LOAD_CYCLES = 9'h100;

	// Pixel groups per load for each multiplex ratio.
	localparam logic [2:0] GROUPS_4 = 3'h4;
	localparam logic [2:0] GROUPS_5 = 3'h5;

	// Pipeline delay constant; the wait counter starts at this less 6, giving six pixel clocks from load pin edge to first pixel out.
	localparam int PIPE_DELAY_CLKS = 8;

	// Single-channel red-green-blue cycle codes.
	localparam logic [1:0] PHASE_RED = 2'h0;
	localparam logic [1:0] PHASE_GREEN = 2'h1;
	localparam logic [1:0] PHASE_BLUE = 2'h2;

endpackage

/* File: core/ppc_regs.sv */
// Control registers and pixel processing of the colour palette converter.
`timescale 1ns/1ps
module ppc_regs #(
	parameter bit SINGLE_CHANNEL = 1'b0,
	parameter int GROUPS = 5,
	parameter int PLANES = 8
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_i,
	// Processor port pins.
	input wire logic ce_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [1:0] reg_sel_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_o,
	// Single-channel colour cycle from the address logic.
	input wire logic pal_access_i,
	input wire logic [1:0] rgb_phase_i,
	output logic pal_take_o,
	// Frame buffer pins.
	input wire logic pixel_load_strobe_n_i,
	input wire logic blank_n_i,
	input wire logic [GROUPS*PLANES-1:0] pixel_plane_inputs_i,
	input wire logic [GROUPS-1:0] overlay_select_hi_i,
	input wire logic [GROUPS-1:0] overlay_select_lo_i,
	// Pipeline delay reset.
	input wire logic pipe_reset_i,
	output logic realign_pending_o,
	// DAC inputs for readback.
	input wire logic [7:0] dac_red_i,
	input wire logic [7:0] dac_green_i,
	input wire logic [7:0] dac_blue_i,
	// Processed pixel out.
	output logic [PLANES-1:0] pix_index_o,
	output logic [1:0] pix_overlay_o,
	output logic pix_use_palette_o,
	output logic pix_valid_o
);

	localparam int SW = 5 + 2 + 8 + GROUPS * (PLANES + 2);
	// Width of the wait counter between the load edge and the first group out.
	localparam int PIPE_DELAY_W = 4;

	// Whole register state of the block. The hold stage keeps the groups of the
	// latest load edge while the output stage is still releasing the previous set.
	typedef struct packed {
		logic [SW-1:0] meta;
		logic [SW-1:0] sync;
		logic ld_prev;
		logic act_prev;
		logic [7:0] cmd;
		logic [7:0] rmask;
		logic [7:0] bmask;
		logic [3:0] test;
		logic last_ratio;
		logic realign;
		logic [GROUPS-1:0][PLANES-1:0] pix;
		logic [GROUPS-1:0] ohi;
		logic [GROUPS-1:0] olo;
		// Hold stage filled on each load edge.
		logic [GROUPS-1:0][PLANES-1:0] hpix;
		logic [GROUPS-1:0] hohi;
		logic [GROUPS-1:0] holo;
		logic [2:0] grp;
		logic run;
		logic [PIPE_DELAY_W-1:0] wait_cnt;
		logic [8:0] blank_cnt;
		logic [6:0] blink_cnt;
		logic blink_on;
		logic [7:0] dout;
		logic doe;
		logic take;
		logic [PLANES-1:0] idx;
		logic [1:0] ovl;
		logic use_pal;
		logic valid;
	} ppc_state_t;

	ppc_state_t q;
	ppc_state_t d;

	// Field views of the synchronised pins.
	logic s_ld_n;
	logic s_blank_n;
	logic s_ce_n;
	logic s_wr_n;
	logic s_rd_n;
	logic [1:0] s_sel;
	logic [7:0] s_din;
	logic [GROUPS*PLANES-1:0] s_pix;
	logic [GROUPS-1:0] s_ohi;
	logic [GROUPS-1:0] s_olo;

	assign {s_ld_n, s_blank_n, s_ce_n, s_wr_n, s_rd_n, s_sel, s_din, s_pix, s_ohi, s_olo} = q.sync;

	// Pick the readback DAC nibble.
	function automatic logic [3:0] dac_nibble(input logic [3:0] t, input logic [7:0] r,
			input logic [7:0] g, input logic [7:0] b);
		logic [7:0] c;
		c = t[ppc_pkg::TST_BLUE] ? b : (t[ppc_pkg::TST_GREEN] ? g : r);
		if (SINGLE_CHANNEL) begin
			c = r;
		end
		return t[ppc_pkg::TST_LOW_NIBBLE] ? c[3:0] : c[7:4];
	endfunction

	// On length and whole period of a blink rate code.
	function automatic logic [14:0] blink_len(input logic [1:0] rate);
		case (rate)
			ppc_pkg::RATE_16_48: blink_len = {ppc_pkg::BLINK_ON_16, ppc_pkg::BLINK_PERIOD_64};
			ppc_pkg::RATE_16_16: blink_len = {ppc_pkg::BLINK_ON_16, ppc_pkg::BLINK_PERIOD_32};
			ppc_pkg::RATE_32_32: blink_len = {ppc_pkg::BLINK_ON_32, ppc_pkg::BLINK_PERIOD_64};
			default: blink_len = {ppc_pkg::BLINK_ON_64, ppc_pkg::BLINK_PERIOD_128};
		endcase
	endfunction

	always_comb begin
		logic wr_act;
		logic rd_act;
		logic ld_edge;
		logic retrace;
		logic blank_off;
		logic [14:0] bl;
		logic [7:0] next_cnt;
		logic [2:0] groups;
		logic [PLANES-1:0] p;
		logic ohi;
		logic olo;
		logic load_now;
		wr_act = 1'b0;
		load_now = 1'b0;
		rd_act = 1'b0;
		ld_edge = 1'b0;
		retrace = 1'b0;
		blank_off = 1'b0;
		bl = 15'h0000;
		next_cnt = 8'h00;
		groups = ppc_pkg::GROUPS_4;
		p = '0;
		ohi = 1'b0;
		olo = 1'b0;
		d = q;

		// The strobe, blanking, processor port and pixel pins pass two flip-flops first.
		d.meta = {pixel_load_strobe_n_i, blank_n_i, ce_n_i, wr_n_i, rd_n_i, reg_sel_i, data_i,
			pixel_plane_inputs_i, overlay_select_hi_i, overlay_select_lo_i};
		d.sync = q.meta;

		// Processor writes are taken once, on the start of a write strobe.
		// The data pins are synchronised together with the strobe, so the byte that
		// is stored is the one that stood on the bus as the strobe fell.
		wr_act = !s_ce_n && !s_wr_n;
		rd_act = !s_ce_n && !s_rd_n && s_wr_n;
		d.act_prev = wr_act;
		if (wr_act && !q.act_prev) begin
			case (s_sel)
				ppc_pkg::IDX_READ_MASK: d.rmask = s_din;
				ppc_pkg::IDX_BLINK_MASK: d.bmask = s_din;
				ppc_pkg::IDX_COMMAND: d.cmd = s_din;
				ppc_pkg::IDX_TEST: d.test = s_din[3:0];
				default: d.test = q.test;
			endcase
		end

		// Reads drive the bus while chip enable and read strobe are low.
		// The test readback samples the DAC inputs every clock, so the host must
		// keep the pixel stream steady for the whole read to get one coherent nibble.
		d.doe = rd_act;
		case (s_sel)
			ppc_pkg::IDX_READ_MASK: d.dout = q.rmask;
			ppc_pkg::IDX_BLINK_MASK: d.dout = q.bmask;
			ppc_pkg::IDX_COMMAND: d.dout = q.cmd;
			ppc_pkg::IDX_TEST: d.dout = {dac_nibble(q.test, dac_red_i, dac_green_i,
				dac_blue_i), q.test};
			default: d.dout = 8'h00;
		endcase

		// Single-channel colour cycle participation.
		// With no colour enable set every data cycle is ours; with one set, only the
		// matching colour cycle of each red-green-blue access is taken or driven.
		if (!SINGLE_CHANNEL || q.test[2:0] == 3'h0) begin
			d.take = pal_access_i;
		end else begin
			case (rgb_phase_i)
				ppc_pkg::PHASE_RED: d.take = pal_access_i && q.test[ppc_pkg::TST_RED];
				ppc_pkg::PHASE_GREEN: d.take = pal_access_i && q.test[ppc_pkg::TST_GREEN];
				ppc_pkg::PHASE_BLUE: d.take = pal_access_i && q.test[ppc_pkg::TST_BLUE];
				default: d.take = 1'b0;
			endcase
		end

		// Load strobe edge and vertical retrace detection.
		// The blanking counter saturates, so one long blanking interval gives exactly
		// one retrace pulse however long it lasts.
		d.ld_prev = s_ld_n;
		ld_edge = s_ld_n && !q.ld_prev;
		if (s_blank_n) begin
			d.blank_cnt = 9'h000;
		end else if (ld_edge && q.blank_cnt != ppc_pkg::RETRACE_LOAD_CYCLES) begin
			d.blank_cnt = q.blank_cnt + 9'h001;
			retrace = (q.blank_cnt + 9'h001) == ppc_pkg::RETRACE_LOAD_CYCLES;
		end

		// Blink phase advances once per retrace interval.
		// Stepping only at retrace keeps a colour change out of the visible picture.
		// The counter runs over the whole period; the phase is on below the on length.
		bl = blink_len(q.cmd[ppc_pkg::CMD_RATE_HI:ppc_pkg::CMD_RATE_LO]);
		if (retrace) begin
			next_cnt = {1'b0, q.blink_cnt} + 8'h01;
			if (next_cnt >= bl[7:0]) begin
				next_cnt = 8'h00;
			end
			d.blink_cnt = next_cnt[6:0];
			d.blink_on = next_cnt[6:0] < bl[14:8];
		end
		blank_off = !q.blink_on;

		// A ratio change leaves the delay unfixed until the next pipeline reset.
		// The flag tells the host that a pipeline reset is still owed.
		d.last_ratio = q.cmd[ppc_pkg::CMD_MUX_RATIO];
		if (q.last_ratio != q.cmd[ppc_pkg::CMD_MUX_RATIO]) begin
			d.realign = 1'b1;
		end

		// Groups are caught in the hold stage on the load edge. After the wait they move
		// to the output stage, which releases one group per clock. The move lands as the
		// previous run ends, so a steady strobe gives pixels with no gap at either ratio.
		groups = q.cmd[ppc_pkg::CMD_MUX_RATIO] ? ppc_pkg::GROUPS_5 : ppc_pkg::GROUPS_4;
		load_now = q.wait_cnt == PIPE_DELAY_W'(1);
		if (ld_edge) begin
			for (int g = 0; g < GROUPS; g++) begin
				d.hpix[g] = s_pix[g*PLANES +: PLANES];
			end
			d.hohi = s_ohi;
			d.holo = s_olo;
			d.wait_cnt = PIPE_DELAY_W'(ppc_pkg::PIPE_DELAY_CLKS - 6);
		end else if (q.wait_cnt != '0) begin
			d.wait_cnt = q.wait_cnt - PIPE_DELAY_W'(1);
		end
		if (load_now) begin
			d.pix = q.hpix;
			d.ohi = q.hohi;
			d.olo = q.holo;
			d.grp = 3'h0;
			d.run = 1'b1;
		end else if (q.run) begin
			if (q.grp + 3'h1 >= groups) begin
				d.run = 1'b0;
			end else begin
				d.grp = q.grp + 3'h1;
			end
		end

		// Colour selection for the current group.
		p = q.pix[q.grp] & q.rmask;
		if (blank_off) begin
			p = p & ~q.bmask;
		end
		ohi = q.ohi[q.grp] && q.cmd[ppc_pkg::CMD_HI_DISPLAY];
		olo = q.olo[q.grp] && q.cmd[ppc_pkg::CMD_LO_DISPLAY];
		if (q.cmd[ppc_pkg::CMD_HI_BLINK] && blank_off) begin
			ohi = 1'b0;
		end
		if (q.cmd[ppc_pkg::CMD_LO_BLINK] && blank_off) begin
			olo = 1'b0;
		end
		d.valid = q.run;
		d.ovl = {ohi, olo};
		d.use_pal = !ohi && !olo && q.cmd[ppc_pkg::CMD_RAM_ENABLE];
		d.idx = d.use_pal ? p : '0;

		// Sequencing state resets; the host-loaded registers keep no reset value.
		if (reset_i || pipe_reset_i) begin
			d.run = 1'b0;
			d.grp = 3'h0;
			d.wait_cnt = '0;
			d.valid = 1'b0;
			d.realign = 1'b0;
		end
		if (reset_i) begin
			// The synchronisers keep running through reset and the edge detector starts
			// at the idle high level of the strobe, so no false load edge follows reset.
			d.ld_prev = 1'b1;
			d.act_prev = 1'b0;
			d.blank_cnt = 9'h000;
			d.blink_cnt = 7'h00;
			d.blink_on = 1'b1;
			d.doe = 1'b0;
			d.dout = 8'h00;
			d.take = 1'b0;
			d.idx = '0;
			d.ovl = 2'h0;
			d.use_pal = 1'b0;
			d.last_ratio = q.cmd[ppc_pkg::CMD_MUX_RATIO];
		end
	end

	always_ff @(posedge clk_i) begin
		q <= d;
	end

	assign data_o = q.dout;
	assign data_oe_o = q.doe;
	assign pal_take_o = q.take;
	assign realign_pending_o = q.realign;
	assign pix_index_o = q.idx;
	assign pix_overlay_o = q.ovl;
	assign pix_use_palette_o = q.use_pal;
	assign pix_valid_o = q.valid;

endmodule // ppc_regs

/* File: tb/ppc_asserts.sv */
// Port-level assertions for the palette pixel control registers.
`timescale 1ns/1ps
module ppc_asserts #(
	parameter int PLANES = 8
) (
	// Clock, reset and processor port.
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic data_oe_o,
	// Pixel path.
	input wire logic pipe_reset_i,
	input wire logic realign_pending_o,
	input wire logic pix_valid_o,
	input wire logic pix_use_palette_o,
	input wire logic [1:0] pix_overlay_o,
	input wire logic [PLANES-1:0] pix_index_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence s_rd_held;
		(!ce_n_i && !rd_n_i && wr_n_i) [*4];
	endsequence
	sequence s_idle;
		ce_n_i [*4];
	endsequence
	a_read_drives: assert property (s_rd_held |-> data_oe_o)
		else $error("bus not driven during read");
	a_idle_quiet: assert property (s_idle |-> !data_oe_o)
		else $error("bus driven while not selected");
	a_drive_cause: assert property ($rose(data_oe_o) |-> !ce_n_i && !rd_n_i)
		else $error("bus driven without a read");
	a_reset_quiet: assert property (disable iff (1'b0)
		reset_i |=> !data_oe_o && !pix_valid_o && !realign_pending_o)
		else $error("outputs active after reset");
	a_run_length: assert property ($rose(pix_valid_o) |-> pix_valid_o [*4])
		else $error("pixel run shorter than four");
	a_palette_no_ovl: assert property (pix_use_palette_o |-> pix_overlay_o == 2'h0)
		else $error("palette chosen with overlay set");
	a_ovl_index_zero: assert property (pix_valid_o && !pix_use_palette_o |-> pix_index_o == '0)
		else $error("index not zero for overlay");
	a_realign_clear: assert property (pipe_reset_i |=> !realign_pending_o)
		else $error("realign flag not cleared");
endmodule // ppc_asserts

bind ppc_regs ppc_asserts #(.PLANES(PLANES)) u_chk (.*);

/* File: tb/ppc_host.sv */
// Host processor model driving the byte-wide register port.
`timescale 1ns/1ps
module ppc_host (
	// Clock.
	input wire logic clk_i,
	// Register port.
	output logic ce_n_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic [1:0] sel_o,
	output logic [7:0] dat_o,
	input wire logic [7:0] dat_i
);
	initial begin
		ce_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		sel_o = 2'h0;
		dat_o = 8'h00;
	end
	// One access; a released data bus shows the inverse of its last value.
	task automatic acc(input logic w, input logic [1:0] s, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk_i);
		ce_n_o = 1'b0;
		sel_o = s;
		rd_n_o = w;
		wr_n_o = !w;
		if (w) dat_o = d;
		repeat (6) @(negedge clk_i);
		q = dat_i;
		ce_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		dat_o = ~dat_o;
		repeat (4) @(negedge clk_i);
	endtask
endmodule // ppc_host

/* File: tb/tb_top.sv */
// Self-checking bench for the palette pixel control registers.
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 0, reset_i = 1, strb_n = 1, blank_n = 1, prst = 0, run = 0;
	logic ce_n, rd_n, wr_n, puse, pval, rpend, ptake, pacc = 0;
	logic [1:0] sel, povl;
	logic [7:0] di, dq, q, w, rm, bm, pidx, dr = 0, dg = 0, db = 0;
	logic [39:0] px = 0;
	logic [4:0] ohi = 0, olo = 0;
	int n_mismatch = 0, cmp_count = 0, lr = 5, cc = 0;
	always #2.5 clk_i = ~clk_i;
	always @(negedge clk_i) begin
		cc = (cc + 1) % lr;
		strb_n <= !run || cc >= 2;
	end
	ppc_host u_host (.clk_i(clk_i), .ce_n_o(ce_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
		.sel_o(sel), .dat_o(di), .dat_i(dq));
	ppc_regs dut (.clk_i(clk_i), .reset_i(reset_i), .ce_n_i(ce_n), .rd_n_i(rd_n),
		.wr_n_i(wr_n), .reg_sel_i(sel), .data_i(di), .data_o(dq), .data_oe_o(),
		.pal_access_i(pacc), .rgb_phase_i(2'h0), .pal_take_o(ptake),
		.pixel_load_strobe_n_i(strb_n), .blank_n_i(blank_n),
		.pixel_plane_inputs_i(px), .overlay_select_hi_i(ohi), .overlay_select_lo_i(olo),
		.pipe_reset_i(prst), .realign_pending_o(rpend), .dac_red_i(dr),
		.dac_green_i(dg), .dac_blue_i(db), .pix_index_o(pidx), .pix_overlay_o(povl),
		.pix_use_palette_o(puse), .pix_valid_o(pval));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			$display("FAIL %0t got %h expected %h", $time, g, e);
			n_mismatch++;
		end
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic logic [7:0] texp(input logic [7:0] t);
		logic [7:0] c;
		c = t[0] ? dr : (t[1] ? dg : db);
		return {t[3] ? c[3:0] : c[7:4], t[3:0]};
	endfunction
	// Stops the load strobe, realigns the pipeline and restarts the strobe with a period of r clocks.
	task automatic align(input int r);
		run = 0;
		repeat (20) @(negedge clk_i);
		lr = r;
		prst = 1;
		@(negedge clk_i);
		prst = 0;
		run = 1;
	endtask
	// Checks n groups in order, then the wrap back to the first.
	task automatic pix(input int n, input logic [7:0] m);
		int k;
		k = 0;
		while (pval !== 1'b1 && k < 60) begin
			@(negedge clk_i);
			k++;
		end
		if (k == 60) begin
			n_mismatch++;
			end_sim;
		end
		for (int g = 0; g <= n; g++) begin
			chk(pidx, px[(g % n) * 8 +: 8] & m);
			@(negedge clk_i);
		end
	endtask
	initial begin
		void'($urandom(54751));
		repeat (16) @(negedge clk_i);
		reset_i = 0;
		for (int i = 0; i < 3; i++) begin
			w = 8'($urandom);
			u_host.acc(1, 2'(i), w, q);
			u_host.acc(0, 2'(i), 8'h00, q);
			chk(q, w);
		end
		for (int i = 0; i < 6; i++) begin
			{dr, dg, db} = 24'($urandom);
			w = {4'($urandom), 1'(i % 2), 3'(1 << (i / 2))};
			u_host.acc(1, 2'h3, w, q);
			u_host.acc(0, 2'h3, 8'h00, q);
			chk(q, texp(w));
		end
		pacc = 1;
		repeat (4) @(negedge clk_i);
		chk({7'h0, ptake}, 8'h01);
		pacc = 0;
		repeat (2) @(negedge clk_i);
		chk({7'h0, ptake}, 8'h00);
		$display("register test done");
		px = {8'($urandom), 32'($urandom)};
		rm = 8'($urandom);
		u_host.acc(1, 2'h0, rm, q);
		u_host.acc(1, 2'h1, 8'h00, q);
		u_host.acc(1, 2'h2, 8'hd3, q);
		align(5);
		pix(5, rm);
		u_host.acc(1, 2'h2, 8'h53, q);
		chk({7'h0, rpend}, 8'h01);
		align(4);
		chk({7'h0, rpend}, 8'h00);
		pix(4, rm);
		u_host.acc(1, 2'h2, 8'hd3, q);
		align(5);
		$display("multiplex test done");
		ohi = 5'h1f;
		olo = 5'h1f;
		for (int o = 0; o < 8; o++) begin
			u_host.acc(1, 2'h2, {1'b1, 1'(o / 4), 4'h1, 2'(o)}, q);
			repeat (20) @(negedge clk_i);
			chk({5'h0, puse, povl}, {5'h0, o == 4, 2'(o)});
		end
		ohi = 5'h00;
		olo = 5'h00;
		$display("overlay test done");
		bm = 8'($urandom);
		u_host.acc(1, 2'h1, bm, q);
		u_host.acc(1, 2'h2, 8'hd3, q);
		for (int f = 1; f <= 16; f++) begin
			blank_n = 0;
			repeat (1310) @(negedge clk_i);
			blank_n = 1;
			align(5);
			pix(5, f < 16 ? rm : rm & ~bm);
		end
		$display("blink test done");
		end_sim;
	end
endmodule // tb_top
